// ### rtl/osc_clock_map.vh
// Register map, field layout, reset values and timing constants of the clock block
`ifndef OSC_CLOCK_MAP_VH
`define OSC_CLOCK_MAP_VH
// Register byte offsets
`define TUNE_OFS 4'h0
`define CTRL_OFS 4'h4
`define CFG_OFS 4'h8
`define STAT_OFS 4'hC
// Tuning register fields
`define TUNE_LFS 7
`define TUNE_MEN 6
`define TUNE_FLD 5:0
`define TUNE_RST 8'h00
// Control register field
`define CTRL_FSEL 6:4
`define FSEL_RST 3'h6
`define FSEL_SLOW 3'h0
// Configuration register fields
`define CFG_MODE 2:0
`define CFG_CPS 4:3
`define CFG_PRE 7:5
`define CFG_MEN 8
`define CFG_CHOICE 9
`define CFG_PWRT 10
`define CFG_FAIL_SAFE_CLOCK_MONITOR 11
`define CFG_WDT 12
`define CFG_TWOSPD 13
`define CFG_RST 14'h0100
// Oscillator modes
`define MODE_INT 3'h0
`define MODE_INT_CO 3'h1
`define MODE_INT_M 3'h2
`define MODE_INT_M_CO 3'h3
`define MODE_HS 3'h4
`define MODE_HS_M 3'h5
`define MODE_EC 3'h6
`define MODE_EC_M 3'h7
// AXI responses
`define RESP_OK 2'h0
`define RESP_SLVERR 2'h2
// Rates: clock 200 MHz, fractions on a 16-bit phase accumulator
`define CLK_MHZ 200
`define FAST_STEP 16'hA3D
`define CORE48_STEP 16'h3D71
`define TUNE_SHIFT 3
`define TUNE_RATE 16'h4
// Times
`define LOCK_NS 2000
`define SETTLE_NS 1000
`define RC_KHZ 31
`define OST_TICKS 10'h3FF
`endif

// ### rtl/osc_clock_ctrl.v
// Clock generation: postscalers, multipliers, internal sources and register slave
`timescale 1ns/100ps
`include "osc_clock_map.vh"
module osc_clock_ctrl #(
  parameter LOCK_CYCLES = (`LOCK_NS * `CLK_MHZ) / 1000,
  parameter RC_DIV = (`CLK_MHZ * 1000) / `RC_KHZ
) (
  input wire aclk, // System clock, 200 MHz
  input wire aresetn, // Synchronous reset, active low
  input wire [3:0] s_axi_awaddr, // Write address
  input wire s_axi_awvalid, // Write address valid
  output reg s_axi_awready, // Write address ready
  input wire [31:0] s_axi_wdata, // Write data
  input wire [3:0] s_axi_wstrb, // Write byte enables
  input wire s_axi_wvalid, // Write data valid
  output reg s_axi_wready, // Write data ready
  output reg [1:0] s_axi_bresp, // Write response
  output reg s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire [3:0] s_axi_araddr, // Read address
  input wire s_axi_arvalid, // Read address valid
  output reg s_axi_arready, // Read address ready
  output reg [31:0] s_axi_rdata, // Read data
  output reg [1:0] s_axi_rresp, // Read response
  output reg s_axi_rvalid, // Read data valid
  input wire s_axi_rready, // Read data ready
  input wire oscillator_input_pin, // External clock or crystal input
  output reg oscillator_output_pin, // Divided clock out
  output reg oscillator_output_pin_oe, // Pin driven while high
  output reg core_tick, // One-cycle enable per core clock
  output reg slow_rc_run // Slow RC source running
);
  localparam SETTLE_CYCLES = (`SETTLE_NS * `CLK_MHZ) / 1000;

  // Divide-by-2^k mask of the fast-source postscaler
  function [7:0] ps_mask;
    input [2:0] sel;
    begin
      case (sel)
        3'h7: ps_mask = 8'h00;
        3'h6: ps_mask = 8'h01;
        3'h5: ps_mask = 8'h03;
        3'h4: ps_mask = 8'h07;
        3'h3: ps_mask = 8'h0F;
        3'h2: ps_mask = 8'h1F;
        3'h1: ps_mask = 8'h3F;
        default: ps_mask = 8'hFF;
      endcase
    end
  endfunction

  // Modes that may use a multiplier
  function mult_mode;
    input [2:0] m;
    begin
      mult_mode = (m == `MODE_INT_M) || (m == `MODE_INT_M_CO) ||
                  (m == `MODE_HS_M) || (m == `MODE_EC_M);
    end
  endfunction

  // Modes clocked by the internal sources, fast or slow RC
  function int_mode;
    input [2:0] m;
    begin
      int_mode = (m[2] == 1'b0);
    end
  endfunction

  // Registers
  reg [7:0] tuning_register;
  reg [2:0] internal_freq_select;
  reg [13:0] cfg;
  wire low_freq_source_select = tuning_register[`TUNE_LFS];
  wire multiplier_enable_bit = tuning_register[`TUNE_MEN];
  wire [5:0] tuning_field = tuning_register[`TUNE_FLD];
  wire [2:0] mode = cfg[`CFG_MODE];
  wire [1:0] core_postscale_select = cfg[`CFG_CPS];
  wire [2:0] prescale_select = cfg[`CFG_PRE];
  wire config_multiplier_enable = cfg[`CFG_MEN];
  wire multiplier_choice_bit = cfg[`CFG_CHOICE];
  wire ext_mode = (mode == `MODE_EC) || (mode == `MODE_EC_M);
  wire hs_mode = (mode == `MODE_HS) || (mode == `MODE_HS_M);

  // Pin synchroniser; edge detect reads only the second and third stages
  reg osc_s1, osc_s2, osc_s3;
  always @(posedge aclk) begin
    if (!aresetn) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
    end else begin
      osc_s1 <= oscillator_input_pin;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
    end
  end
  wire osc_tick = osc_s2 & ~osc_s3;

  // Fast source: signed tuning offsets the phase step, slewing gradually
  wire [15:0] tune_off = {{(10 - `TUNE_SHIFT){tuning_field[5]}}, tuning_field,
                          {`TUNE_SHIFT{1'b0}}};
  wire [15:0] fast_target = `FAST_STEP + tune_off;
  reg [15:0] fast_step, fast_acc;
  wire [16:0] fast_sum = {1'b0, fast_acc} + {1'b0, fast_step};
  wire fast_tick = fast_sum[16];
  // Slew bounded by TUNE_RATE so the full range settles within SETTLE_CYCLES;
  // no completion flag exists, software cannot observe the end of the shift
  always @(posedge aclk) begin
    if (!aresetn) begin
      fast_step <= `FAST_STEP;
      fast_acc <= 16'h0000;
    end else begin
      fast_acc <= fast_sum[15:0];
      if ($signed(fast_target - fast_step) > $signed(`TUNE_RATE))
        fast_step <= fast_step + `TUNE_RATE;
      else if ($signed(fast_step - fast_target) > $signed(`TUNE_RATE))
        fast_step <= fast_step - `TUNE_RATE;
      else
        fast_step <= fast_target;
    end
  end

  // Slow RC source runs when it clocks an internal mode without multiplier, or when a feature needs it
  wire rc_selected = int_mode(mode) && !mult_mode(mode) &&
                     internal_freq_select == `FSEL_SLOW && !low_freq_source_select;
  wire next_rc_run = rc_selected | cfg[`CFG_PWRT] | cfg[`CFG_FAIL_SAFE_CLOCK_MONITOR] |
                     cfg[`CFG_WDT] | cfg[`CFG_TWOSPD];
  reg [15:0] rc_cnt;
  wire rc_tick = slow_rc_run && (rc_cnt == RC_DIV[15:0] - 16'h1);
  always @(posedge aclk) begin
    if (!aresetn) begin
      slow_rc_run <= 1'b0;
      rc_cnt <= 16'h0000;
    end else begin
      slow_rc_run <= next_rc_run;
      if (!slow_rc_run || rc_tick)
        rc_cnt <= 16'h0000;
      else
        rc_cnt <= rc_cnt + 16'h1;
    end
  end

  // Fast-source postscaler and frequency select
  reg [7:0] ps_cnt;
  wire [7:0] mask = ps_mask(internal_freq_select);
  wire ps_tick = fast_tick && ((ps_cnt & mask) == mask);
  wire slow_tick = low_freq_source_select ? ps_tick : rc_tick;
  wire intclk_tick = (internal_freq_select == `FSEL_SLOW) ? slow_tick
                                                        : ps_tick;
  always @(posedge aclk) begin
    if (!aresetn)
      ps_cnt <= 8'h00;
    else if (fast_tick)
      ps_cnt <= ps_cnt + 8'h1;
  end

  // Crystal start-up wait; external clock modes skip it
  reg [9:0] ost_cnt;
  wire ost_done = (ost_cnt == `OST_TICKS);
  always @(posedge aclk) begin
    if (!aresetn)
      ost_cnt <= 10'h000;
    else if (hs_mode && osc_tick && !ost_done)
      ost_cnt <= ost_cnt + 10'h1;
  end
  wire primary_ready = ext_mode || int_mode(mode) || ost_done;
  wire prim_tick = int_mode(mode) ? intclk_tick : (osc_tick & primary_ready);

  // Core postscaler on the primary clock
  reg [2:0] cps_cnt;
  wire [2:0] cps_last = (core_postscale_select == 2'h0) ? 3'h0 :
                        (core_postscale_select == 2'h1) ? 3'h1 :
                        (core_postscale_select == 2'h2) ? 3'h2 : 3'h5;
  wire cps_tick = prim_tick && (cps_cnt >= cps_last);

  // Multiplier enable; a cleared config enable forces it on in multiplier modes, the bit cannot turn it off
  wire mult_on = mult_mode(mode) &&
                 (multiplier_enable_bit || !config_multiplier_enable);

  // Input prescaler of the fixed multiplier: 4,8,12,16,20,24,40,48 MHz to 4 MHz
  reg [3:0] pre_cnt;
  wire [3:0] pre_last = (prescale_select == 3'h6) ? 4'h9 :
                        (prescale_select == 3'h7) ? 4'hB :
                        {1'b0, prescale_select};
  wire pre_tick = prim_tick && (pre_cnt >= pre_last);
  wire mult_in = multiplier_choice_bit ? prim_tick : pre_tick;

  // Lock delay: counted from the first input edge after enable
  reg seen_in, mult_locked;
  reg [15:0] lock_cnt;
  always @(posedge aclk) begin
    if (!aresetn || !mult_on) begin
      seen_in <= 1'b0;
      mult_locked <= 1'b0;
      lock_cnt <= 16'h0000;
    end else begin
      if (mult_in)
        seen_in <= 1'b1;
      if (seen_in && !mult_locked) begin
        if (lock_cnt == LOCK_CYCLES[15:0] - 16'h1)
          mult_locked <= 1'b1;
        else
          lock_cnt <= lock_cnt + 16'h1;
      end
    end
  end

  // Fixed loop: 96 MHz reference halved, modelled as a 48 MHz phase step
  reg [15:0] fix_acc;
  wire [16:0] fix_sum = {1'b0, fix_acc} + {1'b0, `CORE48_STEP};
  wire fix_tick = mult_locked && fix_sum[16];

  // 4x loop: measure input period, tick every quarter of it
  reg [15:0] per_cnt, quarter, q_cnt;
  // Counter holds period minus one at the input edge, so add it back
  wire [15:0] per_len = per_cnt + 16'h1;
  wire q_tick = mult_locked && (q_cnt + 16'h1 >= quarter);
  wire mult_tick = multiplier_choice_bit ? q_tick : fix_tick;
  always @(posedge aclk) begin
    if (!aresetn) begin
      cps_cnt <= 3'h0;
      pre_cnt <= 4'h0;
      fix_acc <= 16'h0000;
      per_cnt <= 16'h0000;
      quarter <= 16'h0001;
      q_cnt <= 16'h0000;
    end else begin
      if (prim_tick)
        cps_cnt <= cps_tick ? 3'h0 : cps_cnt + 3'h1;
      if (prim_tick)
        pre_cnt <= pre_tick ? 4'h0 : pre_cnt + 4'h1;
      fix_acc <= mult_locked ? fix_sum[15:0] : 16'h0000;
      if (mult_in) begin
        per_cnt <= 16'h0000;
        quarter <= (per_len[15:2] == 14'h0) ? 16'h0001
                                             : {2'b00, per_len[15:2]};
      end else if (per_cnt != 16'hFFFE) begin
        per_cnt <= per_cnt + 16'h1;
      end
      q_cnt <= (q_tick || !mult_locked) ? 16'h0000 : q_cnt + 16'h1;
    end
  end

  // Handover only where the old clock starts a fresh period, so no runt pulse
  reg on_mult;
  wire handover = mult_locked && !on_mult && cps_cnt == 3'h0 && !prim_tick;
  wire next_core_tick = on_mult ? mult_tick : cps_tick;
  always @(posedge aclk) begin
    if (!aresetn) begin
      on_mult <= 1'b0;
      core_tick <= 1'b0;
    end else begin
      if (!mult_locked)
        on_mult <= 1'b0;
      else if (handover)
        on_mult <= 1'b1;
      core_tick <= next_core_tick;
    end
  end

  // Divide-by-4 clock output on the second oscillator pin
  reg [1:0] co_cnt;
  reg co_src;
  always @(*) begin
    case (mode)
      `MODE_EC: co_src = osc_tick;
      `MODE_EC_M: co_src = on_mult ? mult_tick : osc_tick;
      `MODE_INT_CO, `MODE_INT_M_CO: co_src = next_core_tick;
      default: co_src = 1'b0;
    endcase
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      co_cnt <= 2'h0;
      oscillator_output_pin <= 1'b0;
      oscillator_output_pin_oe <= 1'b0;
    end else begin
      if (co_src)
        co_cnt <= co_cnt + 2'h1;
      oscillator_output_pin <= co_cnt[1];
      oscillator_output_pin_oe <= ext_mode || mode == `MODE_INT_CO ||
                                  mode == `MODE_INT_M_CO;
    end
  end

  // AXI4-Lite write: address and data taken in either order, then response
  reg [3:0] wr_addr;
  reg [31:0] wr_data;
  reg [3:0] wr_strb;
  reg have_aw, have_w;
  wire wr_go = have_aw && have_w && !s_axi_bvalid;
  wire wr_hit = wr_addr == `TUNE_OFS || wr_addr == `CTRL_OFS ||
                wr_addr == `CFG_OFS || wr_addr == `STAT_OFS;
  always @(posedge aclk) begin
    if (!aresetn) begin
      have_aw <= 1'b0;
      have_w <= 1'b0;
      wr_addr <= 4'h0;
      wr_data <= 32'h0;
      wr_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OK;
      tuning_register <= `TUNE_RST;
      internal_freq_select <= `FSEL_RST;
      cfg <= `CFG_RST;
    end else begin
      s_axi_awready <= !have_aw && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !have_w && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        have_aw <= 1'b1;
        wr_addr <= {s_axi_awaddr[3:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        have_w <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        have_aw <= 1'b0;
        have_w <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `RESP_OK : `RESP_SLVERR;
        // A tuning write starts a gradual frequency shift; the core keeps running
        if (wr_addr == `TUNE_OFS && wr_strb[0])
          tuning_register <= wr_data[7:0];
        if (wr_addr == `CTRL_OFS && wr_strb[0])
          internal_freq_select <= wr_data[`CTRL_FSEL];
        if (wr_addr == `CFG_OFS && wr_strb[0])
          cfg[7:0] <= wr_data[7:0];
        if (wr_addr == `CFG_OFS && wr_strb[1])
          cfg[13:8] <= wr_data[13:8];
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read: one outstanding, status shows live clock state
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RESP_OK;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OK;
        case ({s_axi_araddr[3:2], 2'b00})
          `TUNE_OFS: s_axi_rdata <= {24'h0, tuning_register};
          `CTRL_OFS: s_axi_rdata <= {25'h0, internal_freq_select, 4'h0};
          `CFG_OFS: s_axi_rdata <= {18'h0, cfg};
          `STAT_OFS: s_axi_rdata <= {27'h0, slow_rc_run, on_mult, mult_locked,
                                     mult_on, primary_ready};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ### testbench/osc_clock_monitor.sv
// Concurrent checks on the clock block's bus handshakes and clock pins
`timescale 1ns/100ps
module osc_clock_monitor (
  input wire aclk, // Clock
  input wire aresetn, // Reset, active low
  input wire s_axi_awvalid, // Write address valid
  input wire s_axi_awready, // Write address ready
  input wire s_axi_wvalid, // Write data valid
  input wire s_axi_wready, // Write data ready
  input wire s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire s_axi_arvalid, // Read address valid
  input wire s_axi_arready, // Read address ready
  input wire s_axi_rvalid, // Read data valid
  input wire s_axi_rready, // Read data ready
  input wire oscillator_output_pin, // Divided clock out
  input wire oscillator_output_pin_oe, // Pin enable
  input wire core_tick, // Core clock enable
  input wire slow_rc_run // Slow RC running
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Bus handshakes: pulses, held answers and fixed latencies
  chk_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held past one cycle");
  chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped before bready");
  chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped before rready");
  chk_write_answer: assert property
    (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_read_single: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  // A divided clock is never a one-cycle spike
  chk_pin_width: assert property ($rose(oscillator_output_pin) |=> oscillator_output_pin)
    else $error("divided clock high for one cycle only");
  // Everything quiet on the first edge after reset
  chk_reset_quiet: assert property ($rose(aresetn) |->
    !(core_tick || slow_rc_run || oscillator_output_pin_oe || s_axi_bvalid || s_axi_rvalid))
    else $error("output active straight after reset");
  cov_tick: cover property (core_tick);
  cov_pin: cover property ($rose(oscillator_output_pin));
  cov_write: cover property (s_axi_bvalid && s_axi_bready);
  cov_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind osc_clock_ctrl osc_clock_monitor mon_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .oscillator_output_pin, .oscillator_output_pin_oe,
  .core_tick, .slow_rc_run);

// ### testbench/ext_clock_source.sv
// Behavioural external clock source feeding the oscillator input pin
`timescale 1ns/100ps
module ext_clock_source (
  input wire logic [7:0] half_ns, // Half period in ns
  output logic osc_out // Clock into the oscillator input
);
  // Free running; odd start offset keeps it out of phase with the bench clock
  initial begin
    osc_out = 1'b0;
    #1.3;
    forever begin
      #(half_ns);
      osc_out = ~osc_out;
    end
  end
endmodule

// ### testbench/tb.sv
// Self-checking bench for the clock generation block
`timescale 1ns/100ps
`include "osc_clock_map.vh"
module tb;
  localparam int LOCK = 40;
  localparam int RCD = 50;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rv, st;
  logic oscillator_input_pin, oscillator_output_pin, oscillator_output_pin_oe;
  logic core_tick, slow_rc_run;
  logic [5:0] tv [3] = '{6'h1F, 6'h20, 6'h00};
  int dv [4] = '{1, 2, 3, 6};
  int miscompares = 0, num_checks = 0, cycles = 0, c, r;

  osc_clock_ctrl #(.LOCK_CYCLES(LOCK), .RC_DIV(RCD)) dut_u (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .oscillator_input_pin,
    .oscillator_output_pin, .oscillator_output_pin_oe, .core_tick, .slow_rc_run);
  // 10 MHz source: inside the 4x loop's input range
  ext_clock_source src_u (.half_ns(8'h32), .osc_out(oscillator_input_pin));

  // 200 MHz clock
  always #2.5 aclk = ~aclk;

  // Cut a hang short
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 80000) begin
      miscompares++;
      tally_and_finish;
    end
  end

  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask

  // Rates are counted over a window, so allow a small slack at its ends
  task automatic near(input int got, input int exp, input int tol, input string m);
    num_checks++;
    if (got < exp - tol || got > exp + tol) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %0d exp %0d", $time, m, got, exp);
    end
  endtask

  // Address and data offered together, each released once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, `RESP_OK}, "write response");
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask

  // Count core ticks and rising edges of the divided pin over n cycles
  task automatic cnt(input int n, output int t, output int p);
    logic q;
    t = 0;
    p = 0;
    q = oscillator_output_pin;
    repeat (n) begin
      @(posedge aclk);
      if (core_tick === 1'b1) t++;
      if (oscillator_output_pin === 1'b1 && q === 1'b0) p++;
      q = oscillator_output_pin;
    end
  endtask

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values
    rd(`TUNE_OFS, rv);
    chk(rv, 32'h0, "tuning reset");
    rd(`CTRL_OFS, rv);
    chk(rv, {25'h0, `FSEL_RST, 4'h0}, "control reset");
    rd(`CFG_OFS, rv);
    chk(rv, {18'h0, `CFG_RST}, "config reset");
    chk({31'h0, slow_rc_run}, 32'h0, "rc idle after reset");
    $display("test reset done");
    // Slow RC demanded by each feature, and as selected clock
    for (int b = 10; b < 14; b++) begin
      wr(`CFG_OFS, {18'h0, `CFG_RST} | (32'h1 << b));
      rd(`STAT_OFS, st);
      chk({30'h0, slow_rc_run, st[4]}, 32'h3, "rc on for feature");
    end
    wr(`CFG_OFS, {18'h0, `CFG_RST});
    wr(`CTRL_OFS, 32'h0);
    // The run flag is registered one edge after the select lands
    @(posedge aclk);
    chk({31'h0, slow_rc_run}, 32'h1, "rc on when selected");
    cnt(2000, c, r);
    near(c, 2000 / RCD, 1, "slow rc rate");
    wr(`TUNE_OFS, 32'h80);
    cnt(13000, c, r);
    near(c, 13000 * `FAST_STEP / 65536 / 256, 1, "fast over 256");
    $display("test slow clock done");
    // Postscaler outputs, then tuning extremes at 8 MHz
    for (int f = 7; f > 3; f--) begin
      wr(`CTRL_OFS, 32'(f) << 4);
      cnt(2000, c, r);
      near(c, 2000 * `FAST_STEP / 65536 >> (7 - f), 2, "postscaler rate");
    end
    wr(`CTRL_OFS, 32'h70);
    foreach (tv[i]) begin
      rd(`STAT_OFS, st);
      wr(`TUNE_OFS, {26'h0, tv[i]});
      rd(`STAT_OFS, rv);
      chk(rv, st, "status untouched by tuning");
      repeat (200) @(posedge aclk);
      cnt(2000, c, r);
      near(c, 2000 * (int'(`FAST_STEP) + (int'($signed(tv[i])) <<< `TUNE_SHIFT)) / 65536,
        2, "tuned rate");
    end
    $display("test internal source done");
    // External clock: no start-up wait, pin is input over four, core postscale
    wr(`CFG_OFS, 32'h106);
    cnt(100, c, r);
    near(c, 4, 2, "ticks at once");
    chk({31'h0, oscillator_output_pin_oe}, 32'h1, "pin driven");
    for (int d = 0; d < 4; d++) begin
      wr(`CFG_OFS, 32'h106 | (32'(d) << 3));
      cnt(2400, c, r);
      near(c, 2400 / (20 * dv[d]), 2, "core postscale");
      near(r, 2400 / 80, 1, "pin is input over four");
    end
    wr(`TUNE_OFS, 32'h40);
    rd(`STAT_OFS, st);
    chk(st & 32'hA, 32'h0, "loop kept off");
    $display("test external clock done");
    // Multiplied external clock: wait for lock, then handover
    wr(`CFG_OFS, 32'h107);
    rd(`STAT_OFS, st);
    chk(st & 32'hA, 32'h2, "on, still old clock");
    repeat (LOCK + 60) @(posedge aclk);
    rd(`STAT_OFS, st);
    chk(st & 32'hE, 32'hE, "locked, handed over");
    cnt(2400, c, r);
    near(c, 2400 * `CORE48_STEP / 65536, 2, "fixed loop rate");
    near(r, 2400 * `CORE48_STEP / 65536 / 4, 1, "pin is loop over four");
    wr(`CFG_OFS, 32'h307);
    repeat (LOCK + 60) @(posedge aclk);
    cnt(2400, c, r);
    near(c, 2400 * 4 / 20, 2, "4x loop rate");
    wr(`CFG_OFS, 32'h007);
    wr(`TUNE_OFS, 32'h0);
    rd(`STAT_OFS, st);
    chk(st & 32'h2, 32'h2, "config keeps loop on");
    wr(`CFG_OFS, 32'h106);
    rd(`STAT_OFS, st);
    chk(st & 32'hA, 32'h0, "loop off, back on input");
    cnt(2400, c, r);
    near(c, 2400 / 20, 2, "input rate again");
    $display("test multiplier done");
    // Crystal mode holds the core until start-up, pin released
    wr(`CFG_OFS, 32'h104);
    cnt(100, c, r);
    near(c, 0, 0, "no ticks before start-up");
    rd(`STAT_OFS, st);
    chk(st & 32'h1, 32'h0, "crystal not yet ready");
    chk({31'h0, oscillator_output_pin_oe}, 32'h0, "pin released in crystal mode");
    // Internal source through the fixed loop, core clock out on the pin
    wr(`CFG_OFS, 32'h103);
    wr(`TUNE_OFS, 32'h40);
    repeat (LOCK + 60) @(posedge aclk);
    cnt(2400, c, r);
    near(c, 2400 * `CORE48_STEP / 65536, 2, "internal source multiplied");
    near(r, 2400 * `CORE48_STEP / 65536 / 4, 1, "clock-out is core over four");
    chk({31'h0, oscillator_output_pin_oe}, 32'h1, "clock-out pin driven");
    $display("test other modes done");
    tally_and_finish;
  end
endmodule
